/* hdl/flash_seq_pkg.sv */
// Package with constants, register map and types of the flash command sequencer.
// Overview of operation
// - Command 0x06 programs a phrase; byte gives block
// - Program commands need parameter index 101
// - Program address bits 2:0 must be zero
// - Write four words, read back, then complete
// - Protected address sets protection violation flag
// - Verify errors set verify flag; fatal ones also set uncorrectable
// - Bad mode or invalid address sets access error
// - Command 0x07 programs once; index 0 to 7
// - Program once checks erased, programs, verifies
// - Already programmed once phrase is refused
// - All-ones once phrase may be programmed again
// - Command 0x08 erases all; index must be 000
// - Erase all, verify, release security on pass
// - Any protection blocks commanded erase all
// - Request input starts erase all without command
// - Invalid divider skips request, sets access error
// - Erase all restores divider to reset value
// - Request erase ignores protection, keeps it unchanged
// - Verify pass unsecures state and security byte
// - Pending bit tracks request; verify errors flagged
package flash_seq_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_CLKDIV = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_SECURITY = 8'h0C;
    localparam logic [7:0] OFS_INDEX = 8'h10;
    localparam logic [7:0] OFS_PARAM = 8'h14;
    localparam logic [7:0] OFS_PROTECT = 8'h18;
    localparam logic [7:0] OFS_MODE = 8'h1C;
    // Status register bit positions.
    localparam int ST_CMD_COMPLETE_FLAG = 7;
    localparam int ST_ACCESS_ERROR_FLAG = 5;
    localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
    localparam int ST_VERR = 1;
    localparam int ST_UERR = 0;
    // Config register bit of the request pending indication.
    localparam int CF_PENDING = 0;
    // Divider register: bit 7 marks a loaded setting.
    localparam int DIV_LOADED = 7;
    localparam logic [7:0] CLKDIV_RESET = 8'h00;
    // Security field values.
    localparam logic [1:0] SEC_SECURED = 2'h0;
    localparam logic [1:0] SEC_UNSECURE = 2'h2;
    // Command codes and parameter index needs.
    localparam logic [7:0] CMD_PROGRAM = 8'h06;
    localparam logic [7:0] CMD_ONCE = 8'h07;
    localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
    localparam logic [2:0] IDX_PROGRAM = 3'h5;
    localparam logic [2:0] IDX_ERASE_ALL = 3'h0;
    localparam logic [15:0] ONCE_MAX = 16'h0007;
    // Valid program block, upper global address byte.
    localparam logic [7:0] PBLOCK_HI = 8'h00;
    // Embedded algorithm timing in ns and in 4 ns cycles.
    localparam int CLK_NS = 4;
    localparam int PROG_NS = 40;
    localparam int ERASE_NS = 400;
    localparam int PROG_CYC = (PROG_NS + CLK_NS - 1) / CLK_NS;
    localparam int ERASE_CYC = (ERASE_NS + CLK_NS - 1) / CLK_NS;
    // Sequencer states.
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_BLANK = 6'h02,
        S_PROG = 6'h04,
        S_ERASE = 6'h08,
        S_VERIFY = 6'h10,
        S_DONE = 6'h20
    } seq_state_t;
    // Array port towards the flash macro.
    typedef struct packed {
        logic prog;
        logic erase;
        logic once;
        logic [23:0] addr;
        logic [63:0] data;
    } array_req_t;
endpackage

/* hdl/flash_seq.sv */
// Flash command sequencer for phrase program, program once and erase all.
`timescale 1ns/1ns
module flash_seq
    import flash_seq_pkg::*;
#(
    parameter int ONCE_PHRASES = 8
) (
    // Clock and reset.
    input wire logic clock_in,
    input wire logic srst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Erase-all request from system logic, asynchronous.
    input wire logic erase_req_in,
    // Flash array model port.
    output array_req_t array_out,
    input wire logic array_err_in,
    input wire logic array_fatal_in,
    input wire logic array_blank_in,
    // Security state for the chip.
    output logic [1:0] security_out
);
    // Registers.
    logic [7:0] clkdiv_q;
    logic [7:0] status_q;
    logic pending_q;
    logic [1:0] sec_q;
    logic [2:0] index_q;
    logic [15:0] param_q [6];
    logic [7:0] protect_q;
    logic mode_ok_q;
    logic [ONCE_PHRASES-1:0] once_used_q;
    seq_state_t state_q;
    logic [7:0] timer_q;
    logic [2:0] cmd_q;
    logic from_pin_q;
    logic sync1_q, sync2_q, sync3_q;
    logic [31:0] rdata_q;
    logic ready_q;
    array_req_t array_q;

    // Bus decode; a transfer takes effect only at the edge where ready is seen high.
    // The first access cycle is a wait state, so the master always sees one.
    wire bus_acc = psel_in && penable_in && ready_q;
    wire bus_wr = bus_acc && pwrite_in;
    wire busy = (state_q != S_IDLE);
    wire launch = bus_wr && (paddr_in == OFS_STATUS) && pwdata_in[ST_CMD_COMPLETE_FLAG] && status_q[ST_CMD_COMPLETE_FLAG] && !busy;
    wire pin_rise = sync2_q && !sync3_q;
    wire [23:0] gaddr = {param_q[0][7:0], param_q[1]};
    wire [7:0] opcode = param_q[0][15:8];
    wire [63:0] pdata = {param_q[5], param_q[4], param_q[3], param_q[2]};
    wire all_ones = (pdata == 64'hFFFF_FFFF_FFFF_FFFF);

    // Launch checks evaluated in the launch cycle.
    logic acc_fail, prot_fail;
    always_comb begin
        acc_fail = 1'b0;
        prot_fail = 1'b0;
        case (opcode)
            CMD_PROGRAM: begin
                acc_fail = (index_q != IDX_PROGRAM) || !mode_ok_q
                    || (gaddr[23:16] != PBLOCK_HI) || (gaddr[2:0] != 3'h0);
                prot_fail = protect_q[gaddr[17:15]];
            end
            CMD_ONCE: begin
                acc_fail = (index_q != IDX_PROGRAM) || !mode_ok_q || (param_q[1] > ONCE_MAX)
                    || once_used_q[param_q[1][2:0]];
            end
            CMD_ERASE_ALL: begin
                acc_fail = (index_q != IDX_ERASE_ALL) || !mode_ok_q;
                prot_fail = |protect_q;
            end
            default: acc_fail = 1'b1;
        endcase
    end

    // Two-flop synchroniser plus an edge register for the request.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= erase_req_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Sequencer state machine and its timer.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_q <= S_IDLE;
            timer_q <= 8'h00;
            cmd_q <= 3'h0;
            from_pin_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    // A pin request wins over a launch in the same cycle.
                    if (pin_rise && clkdiv_q[DIV_LOADED]) begin
                        state_q <= S_ERASE;
                        from_pin_q <= 1'b1;
                        timer_q <= 8'(ERASE_CYC);
                    end else if (launch && !acc_fail && !prot_fail) begin
                        cmd_q <= opcode[2:0];
                        from_pin_q <= 1'b0;
                        if (opcode == CMD_ERASE_ALL) begin
                            state_q <= S_ERASE;
                            timer_q <= 8'(ERASE_CYC);
                        end else if (opcode == CMD_ONCE) begin
                            state_q <= S_BLANK;
                        end else begin
                            state_q <= S_PROG;
                            timer_q <= 8'(PROG_CYC);
                        end
                    end
                end
                S_BLANK: begin
                    state_q <= array_blank_in ? S_PROG : S_DONE;
                    timer_q <= 8'(PROG_CYC);
                end
                S_PROG, S_ERASE: begin
                    if (timer_q == 8'h00) begin
                        state_q <= S_VERIFY;
                    end else begin
                        timer_q <= timer_q - 8'h01;
                    end
                end
                S_VERIFY: state_q <= S_DONE;
                S_DONE: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // Array request drive; erase ignores protection on the pin path.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            array_q <= '0;
        end else begin
            array_q.prog <= (state_q == S_PROG);
            array_q.erase <= (state_q == S_ERASE);
            array_q.once <= (cmd_q == CMD_ONCE[2:0]) && (state_q == S_PROG || state_q == S_BLANK);
            array_q.addr <= (cmd_q == CMD_ONCE[2:0]) ? {21'h0, param_q[1][2:0]} : gaddr;
            array_q.data <= pdata;
        end
    end

    // Status flags: set by hardware wins over software clear.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            status_q <= 8'h80;
        end else begin
            if (bus_wr && paddr_in == OFS_STATUS && !busy) begin
                status_q[ST_ACCESS_ERROR_FLAG] <= status_q[ST_ACCESS_ERROR_FLAG] && !pwdata_in[ST_ACCESS_ERROR_FLAG];
                status_q[ST_PROTECTION_VIOLATION_FLAG] <= status_q[ST_PROTECTION_VIOLATION_FLAG] && !pwdata_in[ST_PROTECTION_VIOLATION_FLAG];
            end
            if (launch) begin
                status_q[ST_CMD_COMPLETE_FLAG] <= 1'b0;
                status_q[ST_VERR] <= 1'b0;
                status_q[ST_UERR] <= 1'b0;
                if (acc_fail) begin
                    status_q[ST_ACCESS_ERROR_FLAG] <= 1'b1;
                end else if (prot_fail) begin
                    status_q[ST_PROTECTION_VIOLATION_FLAG] <= 1'b1;
                end
            end
            if (!busy && pin_rise && !clkdiv_q[DIV_LOADED]) begin
                status_q[ST_ACCESS_ERROR_FLAG] <= 1'b1;
            end
            // Unless a refused launch shares its start cycle, a request-started erase also holds the complete flag low while it runs.
            if (!busy && pin_rise && clkdiv_q[DIV_LOADED]) begin
                status_q[ST_CMD_COMPLETE_FLAG] <= 1'b0;
                status_q[ST_VERR] <= 1'b0;
                status_q[ST_UERR] <= 1'b0;
            end
            if (state_q == S_BLANK && !array_blank_in) begin
                status_q[ST_ACCESS_ERROR_FLAG] <= 1'b1;
            end
            if (state_q == S_VERIFY) begin
                status_q[ST_VERR] <= array_err_in || array_fatal_in;
                status_q[ST_UERR] <= array_fatal_in;
            end
            if (launch && (acc_fail || prot_fail)) begin
                status_q[ST_CMD_COMPLETE_FLAG] <= 1'b1;
            end
            if (state_q == S_DONE) begin
                status_q[ST_CMD_COMPLETE_FLAG] <= 1'b1;
            end
        end
    end

    // Security, once-used record and pending bit.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            sec_q <= SEC_SECURED;
            once_used_q <= '0;
            pending_q <= 1'b0;
        end else begin
            if (!busy && pin_rise && clkdiv_q[DIV_LOADED]) begin
                pending_q <= 1'b1;
            end else if (state_q == S_DONE) begin
                pending_q <= 1'b0;
            end
            if (state_q == S_VERIFY && cmd_q == CMD_ERASE_ALL[2:0] || state_q == S_VERIFY && from_pin_q) begin
                if (!array_err_in && !array_fatal_in) begin
                    sec_q <= SEC_UNSECURE;
                end
            end
            if (state_q == S_VERIFY && cmd_q == CMD_ONCE[2:0] && !from_pin_q && !all_ones) begin
                once_used_q[param_q[1][2:0]] <= 1'b1;
            end
        end
    end

    // Software registers; writes are dropped while busy.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            clkdiv_q <= CLKDIV_RESET;
            index_q <= 3'h0;
            protect_q <= 8'h00;
            mode_ok_q <= 1'b1;
            for (int i = 0; i < 6; i++) begin
                param_q[i] <= 16'h0000;
            end
        end else begin
            if (bus_wr && !busy) begin
                case (paddr_in)
                    OFS_CLKDIV: clkdiv_q <= pwdata_in[7:0];
                    OFS_INDEX: index_q <= pwdata_in[2:0];
                    OFS_PARAM: param_q[index_q] <= pwdata_in[15:0];
                    OFS_PROTECT: protect_q <= pwdata_in[7:0];
                    OFS_MODE: mode_ok_q <= pwdata_in[0];
                    default: ;
                endcase
            end
            if (state_q == S_DONE && (from_pin_q || cmd_q == CMD_ERASE_ALL[2:0])) begin
                clkdiv_q <= CLKDIV_RESET;
            end
        end
    end

    // Read mux and one-wait-state ready.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
        end else begin
            ready_q <= psel_in && penable_in && !ready_q;
            case (paddr_in)
                OFS_CLKDIV: rdata_q <= {24'h0, clkdiv_q};
                OFS_STATUS: rdata_q <= {24'h0, status_q};
                OFS_CONFIG: rdata_q <= {31'h0, pending_q};
                OFS_SECURITY: rdata_q <= {30'h0, sec_q};
                OFS_INDEX: rdata_q <= {29'h0, index_q};
                OFS_PARAM: rdata_q <= {16'h0, param_q[index_q]};
                OFS_PROTECT: rdata_q <= {24'h0, protect_q};
                OFS_MODE: rdata_q <= {31'h0, mode_ok_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata_out = rdata_q;
    assign pready_out = ready_q;
    assign pslverr_out = 1'b0;
    assign array_out = array_q;
    assign security_out = sec_q;

    // Assertions.
    sequence launch_s;
        launch && acc_fail;
    endsequence
    bad_launch_a: assert property (@(posedge clock_in) disable iff (srst_in)
        launch_s |=> status_q[ST_ACCESS_ERROR_FLAG] && state_q == S_IDLE) else $error("bad launch not refused");
    prog_start_a: assert property (@(posedge clock_in) disable iff (srst_in)
        launch && !acc_fail && !prot_fail && opcode == CMD_PROGRAM |=> state_q == S_PROG && !status_q[ST_CMD_COMPLETE_FLAG])
        else $error("program did not start");
    cmd_complete_flag_busy_a: assert property (@(posedge clock_in) disable iff (srst_in)
        busy && state_q != S_DONE |=> !status_q[ST_CMD_COMPLETE_FLAG] || state_q == S_IDLE) else $error("cmd_complete_flag set while busy");
    prot_a: assert property (@(posedge clock_in) disable iff (srst_in)
        launch && !acc_fail && prot_fail |=> status_q[ST_PROTECTION_VIOLATION_FLAG] && !busy) else $error("protection ignored");
    verify_a: assert property (@(posedge clock_in) disable iff (srst_in)
        state_q == S_VERIFY && array_fatal_in |=> status_q[ST_UERR] && status_q[ST_VERR])
        else $error("verify flags wrong");
    div_a: assert property (@(posedge clock_in) disable iff (srst_in)
        !busy && pin_rise && !clkdiv_q[DIV_LOADED] |=> status_q[ST_ACCESS_ERROR_FLAG] && !busy) else $error("divider check");
    pend_a: assert property (@(posedge clock_in) disable iff (srst_in)
        !busy && pin_rise && clkdiv_q[DIV_LOADED] |=> pending_q && state_q == S_ERASE) else $error("pending not set");
    reload_a: assert property (@(posedge clock_in) disable iff (srst_in)
        state_q == S_DONE && from_pin_q |=> clkdiv_q == CLKDIV_RESET && !pending_q) else $error("divider not reset");
endmodule

/* verification/flash_array_model.sv */
// Stand-in for the flash array behind the sequencer.
`timescale 1ns/1ns
module flash_array_model
    import flash_seq_pkg::*;
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic srst_in,
    // Request from the sequencer.
    input wire array_req_t req_in,
    // Faults ordered by the bench.
    input wire logic bad_in,
    input wire logic fatal_in,
    // Answers to the sequencer.
    output logic err_out,
    output logic fatal_out,
    output logic blank_out,
    // Target of the last program pulse.
    output logic [23:0] last_addr_out
);
    // Faults appear only when ordered, and an uncorrectable one is also an error.
    assign err_out = bad_in | fatal_in;
    assign fatal_out = fatal_in;
    // The once record lives in the sequencer, so every phrase looks erased here.
    assign blank_out = 1'b1;
    // Keep the phrase address so the bench can check where data went.
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            last_addr_out <= 24'h0;
        end else if (req_in.prog) begin
            last_addr_out <= req_in.addr;
        end
    end
endmodule

/* verification/tb_flash_program_erase_all_sequencer.sv */
// Self-checking bench for the flash command sequencer.
`timescale 1ns/1ns
module tb_flash_program_erase_all_sequencer
    import flash_seq_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic erase_req = 1'b0;
    logic bad = 1'b0;
    logic fatal = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] sec;
    logic [23:0] last_addr;
    logic a_err;
    logic a_fatal;
    logic a_blank;
    array_req_t arr;
    logic [31:0] rd;
    logic [15:0] w1;
    int fails = 0;
    int n_compared = 0;
    int k;

    // Free-running 250 MHz clock.
    always #2 clock = ~clock;

    flash_seq uut (.clock_in(clock), .srst_in(srst), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .erase_req_in(erase_req), .array_out(arr),
        .array_err_in(a_err), .array_fatal_in(a_fatal),
        .array_blank_in(a_blank), .security_out(sec));

    flash_array_model far (.clock_in(clock), .srst_in(srst), .req_in(arr),
        .bad_in(bad), .fatal_in(fatal), .err_out(a_err),
        .fatal_out(a_fatal), .blank_out(a_blank), .last_addr_out(last_addr));

    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (fails == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Compares a register word.
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t reg %h want %h", $time, got, exp);
        end
    endtask

    // Compares the security output.
    task automatic chk_sec(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t sec %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        // A transfer that never completes or that reports an error is a mismatch.
        if (pready !== 1'b1 || pslverr !== 1'b0) begin
            fails++;
            $display("MISMATCH %0t bus transfer failed", $time);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, exp);
    endtask

    // Polls one bit; bounded so a stuck design cannot hang here.
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== v && n < 200);
    endtask

    // Loads six parameter words, launches, and checks the final status.
    task automatic run(input logic [15:0] w0, wa, input logic ones, input logic [2:0] idx,
            input logic [31:0] exp);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFS_INDEX, i);
            apb(1'b1, OFS_PARAM, {16'h0, i == 0 ? w0 : i == 1 ? wa : ones ? 16'hFFFF : 16'($urandom)});
        end
        apb(1'b1, OFS_INDEX, {29'h0, idx});
        apb(1'b1, OFS_STATUS, 32'h30);
        apb(1'b1, OFS_STATUS, 32'h80);
        apb(1'b0, OFS_STATUS, 32'h0);
        if (exp[5:4] == 2'b00) chk_reg({31'h0, rd[ST_CMD_COMPLETE_FLAG]}, 32'h0);
        wait_bit(OFS_STATUS, ST_CMD_COMPLETE_FLAG, 1'b1);
        chk_reg(rd, exp);
    endtask

    // Pulses the system erase-all request; error flags are clear beforehand.
    task automatic pin();
        erase_req <= 1'b1;
        repeat (8) @(posedge clock);
        erase_req <= 1'b0;
    endtask

    // Main sequence.
    initial begin
        void'($urandom(39));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd_chk(OFS_STATUS, 32'h80);
        chk_sec(sec, SEC_SECURED);
        // Divider still unloaded, so the request must be skipped.
        pin();
        rd_chk(OFS_STATUS, 32'hA0);
        chk_sec(sec, SEC_SECURED);
        apb(1'b1, OFS_STATUS, 32'h30);
        apb(1'b1, OFS_CLKDIV, 32'h80);
        // Random aligned phrases below the protected region.
        for (k = 0; k < 4; k++) begin
            w1 = 16'($urandom) & 16'h7FF8;
            run({CMD_PROGRAM, PBLOCK_HI}, w1, 1'b0, IDX_PROGRAM, 32'h80);
            chk_reg({8'h0, last_addr}, {PBLOCK_HI, w1});
        end
        apb(1'b1, OFS_PROTECT, 32'h02);
        run({CMD_PROGRAM, PBLOCK_HI}, 16'h0010, 1'b0, 3'h4, 32'hA0);
        run({CMD_PROGRAM, PBLOCK_HI}, 16'h0014, 1'b0, IDX_PROGRAM, 32'hA0);
        run({CMD_PROGRAM, 8'h01}, 16'h0010, 1'b0, IDX_PROGRAM, 32'hA0);
        run({CMD_PROGRAM, PBLOCK_HI}, 16'h8008, 1'b0, IDX_PROGRAM, 32'h90);
        apb(1'b1, OFS_MODE, 32'h0);
        run({CMD_PROGRAM, PBLOCK_HI}, 16'h0010, 1'b0, IDX_PROGRAM, 32'hA0);
        apb(1'b1, OFS_MODE, 32'h1);
        bad <= 1'b1;
        run({CMD_PROGRAM, PBLOCK_HI}, 16'h0018, 1'b0, IDX_PROGRAM, 32'h82);
        fatal <= 1'b1;
        run({CMD_PROGRAM, PBLOCK_HI}, 16'h0020, 1'b0, IDX_PROGRAM, 32'h83);
        bad <= 1'b0;
        fatal <= 1'b0;
        // Program-once field: range, single use, all-ones exception.
        k = $urandom_range(7, 0);
        run({CMD_ONCE, 8'h00}, 16'h0008, 1'b0, IDX_PROGRAM, 32'hA0);
        run({CMD_ONCE, 8'h00}, 16'((k + 2) % 8), 1'b0, 3'h0, 32'hA0);
        run({CMD_ONCE, 8'h00}, 16'(k), 1'b0, IDX_PROGRAM, 32'h80);
        run({CMD_ONCE, 8'h00}, 16'(k), 1'b0, IDX_PROGRAM, 32'hA0);
        run({CMD_ONCE, 8'h00}, 16'((k + 1) % 8), 1'b1, IDX_PROGRAM, 32'h80);
        run({CMD_ONCE, 8'h00}, 16'((k + 1) % 8), 1'b0, IDX_PROGRAM, 32'h80);
        run({CMD_ONCE, 8'h00}, 16'((k + 1) % 8), 1'b0, IDX_PROGRAM, 32'hA0);
        // Commanded erase-all.
        run({CMD_ERASE_ALL, 8'h00}, 16'h0, 1'b0, 3'h1, 32'hA0);
        run({CMD_ERASE_ALL, 8'h00}, 16'h0, 1'b0, IDX_ERASE_ALL, 32'h90);
        apb(1'b1, OFS_PROTECT, 32'h0);
        run({CMD_ERASE_ALL, 8'h00}, 16'h0, 1'b0, IDX_ERASE_ALL, 32'h80);
        chk_sec(sec, SEC_UNSECURE);
        rd_chk(OFS_CLKDIV, {24'h0, CLKDIV_RESET});
        // Second reset, then a request-started erase with protection set.
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        chk_sec(sec, SEC_SECURED);
        apb(1'b1, OFS_CLKDIV, 32'h80);
        apb(1'b1, OFS_PROTECT, 32'h05);
        pin();
        apb(1'b0, OFS_CONFIG, 32'h0);
        chk_reg({31'h0, rd[CF_PENDING]}, 32'h1);
        wait_bit(OFS_CONFIG, CF_PENDING, 1'b0);
        chk_reg({31'h0, rd[CF_PENDING]}, 32'h0);
        chk_sec(sec, SEC_UNSECURE);
        rd_chk(OFS_PROTECT, 32'h05);
        rd_chk(OFS_CLKDIV, {24'h0, CLKDIV_RESET});
        rd_chk(OFS_STATUS, 32'h80);
        // A failing erase verify on a request-started erase.
        apb(1'b1, OFS_CLKDIV, 32'h80);
        bad <= 1'b1;
        pin();
        wait_bit(OFS_CONFIG, CF_PENDING, 1'b0);
        rd_chk(OFS_STATUS, 32'h82);
        end_sim();
    end

    // Watchdog sized well above the expected run length.
    initial begin
        #240000;
        fails++;
        end_sim();
    end
endmodule
